// File: hdl/byte_reg_bank.sv
// Small bank of byte registers with every word driven straight out on q.
// Assumes one-cycle write strobes from the same clock domain.
`default_nettype none
module byte_reg_bank
  import sleep_wake_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       wr,
  input  wire logic [1:0] waddr,
  input  wire logic [7:0] wdata,
  output logic [31:0]     q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // One write port, all words visible so wake logic sees them at once
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_word
      logic [7:0] word_reg;

      // Each word owns its flop so no two processes share a variable
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          word_reg <= REG_RESET;
        end else if (wr && waddr == 2'(i)) begin
          word_reg <= wdata;
        end
      end

      assign q[i*8 +: 8] = word_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// File: hdl/sleep_wake_pkg.sv
// Constants, register map and carrier types for the sleep/wake sequencer.
// Assumes a single 20 MHz oscillator clock and an 8-bit register port.
package sleep_wake_pkg;

  // ----------------------------------------------------------------
  // Register indices (plain port, byte wide)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_PORTB_IOC   = 4'h0;
  localparam logic [3:0] ADDR_INTCTL      = 4'h1;
  localparam logic [3:0] ADDR_PERIPHERAL_INTERRUPT_ENABLE_1        = 4'h2;
  localparam logic [3:0] ADDR_PERIPHERAL_INTERRUPT_ENABLE_2        = 4'h3;
  localparam logic [3:0] ADDR_PERIPHERAL_INTERRUPT_FLAGS_1        = 4'h4;
  localparam logic [3:0] ADDR_PERIPHERAL_INTERRUPT_FLAGS_2        = 4'h5;
  localparam logic [3:0] ADDR_STATUS      = 4'h6;
  localparam logic [3:0] ADDR_OSC_MODE    = 4'h7;
  localparam logic [3:0] ADDR_EVT_STATUS  = 4'h8;
  localparam logic [3:0] ADDR_EVT_MASK    = 4'h9;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam logic [7:0] PERIPHERAL_INTERRUPT_ENABLE_2_MASK        = 8'h01;
  localparam int         GIE_BIT          = 7;
  localparam int         PERIPHERAL_IRQ_ENABLE_BIT         = 6;
  localparam int         TO_STAT_BIT      = 1;
  localparam int         PD_STAT_BIT      = 0;
  localparam logic [7:0] STATUS_RESET     = 8'h03;
  // Core-register pairs: enable at bit 5..3, flag at bit 2..0
  localparam int         CORE_PAIRS       = 3;
  localparam int         CORE_EN_LSB      = 3;

  // Event bits of the sequencer's own status register
  localparam int         EVT_NOP_SLEEP    = 0;
  localparam int         EVT_REAL_SLEEP   = 1;
  localparam int         EVT_WAKE         = 2;
  localparam int         EVT_WIDTH        = 3;

  // ----------------------------------------------------------------
  // Oscillator modes and timing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    low_power_crystal_mode, crystal_mode, high_speed_crystal_mode,
    external_clock_mode, rc_osc_mode
  } osc_mode_e;

  localparam int          SYS_CLK_HZ        = 20_000_000;
  localparam int          OSC_STARTUP_TOSC  = 1024;
  // One oscillator period is one sys_clk cycle here
  localparam int          OSC_STARTUP_CYC   = OSC_STARTUP_TOSC;
  localparam int          DUMMY_CYCLES      = 2;
  localparam logic [12:0] IRQ_VECTOR        = 13'h0004;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic        sleep_instr;
    logic        watchdog_clear_instr_instr;
    logic [12:0] pc_next;
  } core_op_s;

  typedef struct packed {
    logic        stall;
    logic        vector_req;
    logic [12:0] vector_addr;
    logic        dummy_cycle;
    logic        osc_enable;
    logic        wdt_clear;
  } core_ctl_s;

endpackage

// File: hdl/sleep_wake_seq.sv
// Sleep entry and interrupt wake-up sequencer for a small 8-bit core.
// Assumes the core pulses sleep_instr once per sleep opcode and obeys stall.
//
// The address map and the strobed register port were decided locally.
`default_nettype none
module sleep_wake_seq
  import sleep_wake_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic [7:0] peripheral_interrupt_flags_1_set,
  input  wire logic       peripheral_interrupt_flags_2_set,
  input  wire logic [2:0] core_flag_set,
  input  wire logic       portb_change,
  input  wire core_op_s   core_op,
  input  wire logic       instr_done,
  output core_ctl_s       core_ctl,
  output logic            asleep,
  output logic            irq
);

  // ----------------------------------------------------------------
  // Register port and storage
  // ----------------------------------------------------------------
  reg_req_s    req;
  logic [31:0] bank_q;
  logic [7:0]  intctl_reg;
  logic [7:0]  peripheral_interrupt_flags_1_reg;
  logic [7:0]  peripheral_interrupt_flags_2_reg;
  logic [7:0]  status_reg;
  osc_mode_e   osc_mode_reg;
  logic [EVT_WIDTH-1:0] evt_status_reg;
  logic [EVT_WIDTH-1:0] evt_mask_reg;
  logic [EVT_WIDTH-1:0] evt_set;
  logic [7:0]  rdata_next;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  wire bank_wr = req.wr && (req.addr == ADDR_PORTB_IOC || req.addr == ADDR_PERIPHERAL_INTERRUPT_ENABLE_1
                            || req.addr == ADDR_PERIPHERAL_INTERRUPT_ENABLE_2);
  wire [1:0] bank_sel = (req.addr == ADDR_PERIPHERAL_INTERRUPT_ENABLE_1) ? 2'h1 :
                        (req.addr == ADDR_PERIPHERAL_INTERRUPT_ENABLE_2) ? 2'h2 : 2'h0;

  // Enables live in the small bank; word 3 unused
  byte_reg_bank u_enables (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (bank_wr),
    .waddr   (bank_sel),
    .wdata   (req.wdata),
    .q       (bank_q)
  );

  wire [7:0] ioc_en  = bank_q[7:0];
  wire [7:0] peripheral_interrupt_enable_1    = bank_q[15:8];
  wire [7:0] peripheral_interrupt_enable_2    = bank_q[23:16] & PERIPHERAL_INTERRUPT_ENABLE_2_MASK;

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      peripheral_interrupt_flags_1_reg <= REG_RESET;
      peripheral_interrupt_flags_2_reg <= REG_RESET;
    end else begin
      peripheral_interrupt_flags_1_reg <= ((req.wr && req.addr == ADDR_PERIPHERAL_INTERRUPT_FLAGS_1) ? req.wdata : peripheral_interrupt_flags_1_reg) | peripheral_interrupt_flags_1_set;
      peripheral_interrupt_flags_2_reg <= (((req.wr && req.addr == ADDR_PERIPHERAL_INTERRUPT_FLAGS_2) ? req.wdata : peripheral_interrupt_flags_2_reg)
                   | {7'h00, peripheral_interrupt_flags_2_set}) & PERIPHERAL_INTERRUPT_ENABLE_2_MASK;
    end
  end

  // Interrupt control: enables writable, core flags set by hardware
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intctl_reg <= REG_RESET;
    end else begin
      intctl_reg <= ((req.wr && req.addr == ADDR_INTCTL) ? req.wdata : intctl_reg)
                    | {5'h00, core_flag_set[2:1], core_flag_set[0] | portb_change};
    end
  end

  // Oscillator mode is normally a fuse; kept writable here
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_mode_reg <= crystal_mode;
    end else if (req.wr && req.addr == ADDR_OSC_MODE) begin
      osc_mode_reg <= osc_mode_e'(req.wdata[2:0]);
    end
  end

  // ----------------------------------------------------------------
  // Wake condition
  // ----------------------------------------------------------------
  // Global enable deliberately ignored: pairs alone decide wake
  logic [CORE_PAIRS-1:0] core_pair_hit;
  genvar p;
  generate
    for (p = 0; p < CORE_PAIRS; p++) begin : g_pair
      assign core_pair_hit[p] = intctl_reg[CORE_EN_LSB + p] & intctl_reg[p];
    end
  endgenerate

  wire periph_hit = |(peripheral_interrupt_enable_1 & peripheral_interrupt_flags_1_reg) | |(peripheral_interrupt_enable_2 & peripheral_interrupt_flags_2_reg);
  wire wake_cond  = (|core_pair_hit) | periph_hit;
  wire global_irq_enable        = intctl_reg[GIE_BIT];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum {
    st_run, st_sleep_exec, st_sleeping, st_startup, st_next_instr,
    st_dummy, st_vector
  } seq_e;

  seq_e        state_reg;
  logic [1:0]  dummy_cnt_reg;
  logic        startup_go;
  logic        startup_done;
  logic        real_sleep_pulse;

  startup_timer u_osc_startup_delay (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (startup_go),
    .done    (startup_done)
  );

  wire crystal = (osc_mode_reg == low_power_crystal_mode) ||
                 (osc_mode_reg == crystal_mode) ||
                 (osc_mode_reg == high_speed_crystal_mode);

  assign startup_go = (state_reg == st_sleeping) && wake_cond && crystal;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= st_run;
      dummy_cnt_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        st_run: begin
          // Pending wake at sleep start: stays running, no power-down
          if (core_op.sleep_instr && !wake_cond) begin
            state_reg <= st_sleep_exec;
          end
        end
        st_sleep_exec: begin
          // Sleep opcode completes even if wake shows up meanwhile
          if (instr_done) begin
            state_reg <= wake_cond ? (crystal ? st_sleeping : st_next_instr)
                                   : st_sleeping;
          end
        end
        st_sleeping: begin
          if (wake_cond) begin
            state_reg <= crystal ? st_startup : st_next_instr;
          end
        end
        st_startup: begin
          if (startup_done) begin
            state_reg <= st_next_instr;
          end
        end
        st_next_instr: begin
          if (instr_done) begin
            if (global_irq_enable) begin
              state_reg     <= st_dummy;
              dummy_cnt_reg <= 2'(DUMMY_CYCLES - 1);
            end else begin
              state_reg <= st_run;
            end
          end
        end
        st_dummy: begin
          // Two dummy cycles before the vector fetch
          if (dummy_cnt_reg == 2'h0) begin
            state_reg <= st_vector;
          end else begin
            dummy_cnt_reg <= dummy_cnt_reg - 2'h1;
          end
        end
        st_vector: begin
          state_reg <= st_run;
        end
      endcase
    end
  end

  // Power-down taken once the sleep opcode retires
  assign real_sleep_pulse = (state_reg == st_sleep_exec) && instr_done;

  // ----------------------------------------------------------------
  // Time-out / power-down status
  // ----------------------------------------------------------------
  // No-op sleep never reaches st_sleep_exec, so bits stay put
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_reg <= STATUS_RESET;
    end else if (real_sleep_pulse) begin
      status_reg[TO_STAT_BIT] <= 1'b1;
      status_reg[PD_STAT_BIT] <= 1'b0;
    end else if (core_op.watchdog_clear_instr_instr) begin
      status_reg[TO_STAT_BIT] <= 1'b1;
      status_reg[PD_STAT_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Core control outputs
  // ----------------------------------------------------------------
  always_comb begin
    core_ctl             = '0;
    core_ctl.osc_enable  = (state_reg != st_sleeping);
    core_ctl.stall       = (state_reg == st_sleeping) || (state_reg == st_startup)
                           || (state_reg == st_dummy);
    core_ctl.dummy_cycle = (state_reg == st_dummy);
    core_ctl.vector_req  = (state_reg == st_vector);
    core_ctl.vector_addr = IRQ_VECTOR;
    core_ctl.wdt_clear   = real_sleep_pulse || core_op.watchdog_clear_instr_instr;
  end

  assign asleep = (state_reg == st_sleeping);

  // ----------------------------------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------------------------------
  assign evt_set[EVT_NOP_SLEEP]  = (state_reg == st_run) && core_op.sleep_instr && wake_cond;
  assign evt_set[EVT_REAL_SLEEP] = real_sleep_pulse;
  assign evt_set[EVT_WAKE]       = (state_reg == st_sleeping) && wake_cond;

  // Write-one-to-clear; a set in the same cycle wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_status_reg <= '0;
      evt_mask_reg   <= '0;
    end else begin
      if (req.wr && req.addr == ADDR_EVT_STATUS) begin
        evt_status_reg <= (evt_status_reg & ~req.wdata[EVT_WIDTH-1:0]) | evt_set;
      end else begin
        evt_status_reg <= evt_status_reg | evt_set;
      end
      if (req.wr && req.addr == ADDR_EVT_MASK) begin
        evt_mask_reg <= req.wdata[EVT_WIDTH-1:0];
      end
    end
  end

  assign irq = |(evt_status_reg & evt_mask_reg);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    unique case (req.addr)
      ADDR_PORTB_IOC:  rdata_next = ioc_en;
      ADDR_INTCTL:     rdata_next = intctl_reg;
      ADDR_PERIPHERAL_INTERRUPT_ENABLE_1:       rdata_next = peripheral_interrupt_enable_1;
      ADDR_PERIPHERAL_INTERRUPT_ENABLE_2:       rdata_next = peripheral_interrupt_enable_2;
      ADDR_PERIPHERAL_INTERRUPT_FLAGS_1:       rdata_next = peripheral_interrupt_flags_1_reg;
      ADDR_PERIPHERAL_INTERRUPT_FLAGS_2:       rdata_next = peripheral_interrupt_flags_2_reg;
      ADDR_STATUS:     rdata_next = status_reg;
      ADDR_OSC_MODE:   rdata_next = {5'h00, osc_mode_reg};
      ADDR_EVT_STATUS: rdata_next = {5'h00, evt_status_reg};
      ADDR_EVT_MASK:   rdata_next = {5'h00, evt_mask_reg};
      default:         rdata_next = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= req.rd ? rdata_next : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_nop_no_sleep: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == st_run && core_op.sleep_instr && wake_cond)
    |=> state_reg == st_run)
    else $error("sleep entered with wake pending");

  a_nop_keeps_pd: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == st_run && core_op.sleep_instr && wake_cond && !core_op.watchdog_clear_instr_instr)
    |-> !core_ctl.wdt_clear ##1 $stable(status_reg))
    else $error("no-op sleep touched watchdog status");

  a_real_sets_to: assert property (@(posedge sys_clk) disable iff (rst)
    real_sleep_pulse |-> core_ctl.wdt_clear
    ##1 (status_reg[TO_STAT_BIT] && !status_reg[PD_STAT_BIT]))
    else $error("real sleep status wrong");

  a_wake_leaves: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == st_sleeping && wake_cond) |=> state_reg != st_sleeping)
    else $error("stayed asleep with wake pending");

  a_finish_first: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == st_sleep_exec && !instr_done) |=> state_reg == st_sleep_exec)
    else $error("sleep opcode cut short");

  a_gie_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    (!global_irq_enable && (intctl_reg[CORE_EN_LSB] && intctl_reg[0])) |-> wake_cond)
    else $error("enabled flag missed as wake");

  a_no_osc_startup_delay_ec: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == st_sleeping && wake_cond && !crystal) |=> state_reg == st_next_instr)
    else $error("start-up delay in non-crystal mode");

  a_vector_gap: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == st_next_instr && instr_done && global_irq_enable)
    |=> core_ctl.dummy_cycle [*2] ##1 core_ctl.vector_req)
    else $error("vector not after two dummy cycles");

  a_inline_cont: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == st_next_instr && instr_done && !global_irq_enable) |=> !core_ctl.vector_req [*3])
    else $error("vectored with global enable clear");

  a_startup_wait: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == st_sleeping && wake_cond && crystal)
    |=> (state_reg == st_startup) && !startup_done)
    else $error("crystal wake skipped start-up delay");

  a_sleep_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == st_sleep_exec && instr_done && !wake_cond)
    |=> asleep && !core_ctl.osc_enable)
    else $error("real sleep did not power down");

endmodule
`default_nettype wire

// File: hdl/startup_timer.sv
// Oscillator start-up delay counter.
// Assumes start is a one-cycle pulse from the sequencer on sys_clk.
`default_nettype none
module startup_timer
  import sleep_wake_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      done
);

  logic [10:0] count_reg;
  logic        run_reg;

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  // Counts down one start-up delay, done pulses on the last cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 11'h000;
      run_reg   <= 1'b0;
    end else if (start) begin
      count_reg <= 11'(OSC_STARTUP_CYC - 1);
      run_reg   <= 1'b1;
    end else if (run_reg) begin
      if (count_reg == 11'h000) begin
        run_reg <= 1'b0;
      end else begin
        count_reg <= count_reg - 11'h001;
      end
    end
  end

  assign done = run_reg && (count_reg == 11'h000);

endmodule
`default_nettype wire

// File: verification/core_model.sv
// Model of the core's instruction sequencer facing the sleep sequencer.
// Assumes one clock; an instruction slot is 4 clocks, or 8 when slow is set.
`default_nettype none
module core_model
  import sleep_wake_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst,
  input  wire logic      sleep_req,
  input  wire logic      slow,
  input  wire core_ctl_s core_ctl,
  input  wire logic      asleep,
  output var  core_op_s  core_op,
  output logic           instr_done
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] phase_reg;
  logic [1:0] pend_reg;
  logic       slot_end;

  // Slot end; a stalled or sleeping core retires nothing
  assign slot_end   = (phase_reg == (slow ? 3'h7 : 3'h3));
  assign instr_done = slot_end && !asleep && !core_ctl.stall;

  // Slot counter keeps running so retire timing stays realistic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= slot_end ? 3'h0 : phase_reg + 3'h1;
    end
  end

  // Watchdog clear always goes one slot ahead of the sleep opcode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_reg <= 2'h0;
      core_op  <= '0;
    end else begin
      core_op.watchdog_clear_instr_instr <= 1'b0;
      core_op.sleep_instr  <= 1'b0;
      if (sleep_req) begin
        pend_reg <= 2'h1;
      end else if (phase_reg == 3'h0 && pend_reg != 2'h0 && !core_ctl.stall) begin
        core_op.watchdog_clear_instr_instr <= (pend_reg == 2'h1);
        core_op.sleep_instr  <= (pend_reg == 2'h2);
        pend_reg             <= (pend_reg == 2'h1) ? 2'h2 : 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/sleep_interrupt_wakeup_test.sv
// Self-checking bench for the sleep and interrupt wake-up sequencer.
// Assumes core_model.sv and the sleep_wake_pkg package are compiled first.
`default_nettype none
module sleep_interrupt_wakeup_test
  import sleep_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk = 1'b0;
  logic       rst, reg_wr, reg_rd, peripheral_interrupt_flags_2_set, portb_change, sleep_req, slow;
  logic       asleep, irq, instr_done;
  logic       last_sleep = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, peripheral_interrupt_flags_1_set, rd_val;
  logic [2:0] core_flag_set;
  logic [2:0] dhist;
  core_op_s   core_op;
  core_ctl_s  core_ctl;
  int         num_errors = 0, checks_done = 0, wdt_cnt = 0, vec_cnt = 0, slp_cnt = 0;
  int         src, n, w0, v0, s0;

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  sleep_wake_seq dut_u (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .peripheral_interrupt_flags_1_set(peripheral_interrupt_flags_1_set),
    .peripheral_interrupt_flags_2_set(peripheral_interrupt_flags_2_set), .core_flag_set(core_flag_set), .portb_change(portb_change),
    .core_op(core_op), .instr_done(instr_done), .core_ctl(core_ctl), .asleep(asleep),
    .irq(irq));

  core_model model_u (
    .sys_clk(sys_clk), .rst(rst), .sleep_req(sleep_req), .slow(slow),
    .core_ctl(core_ctl), .asleep(asleep), .core_op(core_op), .instr_done(instr_done));

  // Counts watchdog clears caused by sleep, vectors and sleeping cycles
  // Opcode tracking first, so the clear opcode's own pulse is never counted
  always @(posedge sys_clk) begin
    if (core_op.sleep_instr) last_sleep = 1'b1;
    else if (core_op.watchdog_clear_instr_instr) last_sleep = 1'b0;
    if (core_ctl.wdt_clear && last_sleep) wdt_cnt++;
    if (core_ctl.vector_req) vec_cnt++;
    if (asleep) slp_cnt++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic check_reg(input string what, input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    rd_val = reg_rdata;
    check(what, {8'h00, rd_val}, {8'h00, e});
  endtask

  // Bounded wait: 0 asleep, 1 vector request, 2 sleep opcode
  task automatic wait_cond(input int which, input logic lvl, input int bound);
    logic s;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      dhist = {dhist[1:0], core_ctl.dummy_cycle};
      s = (which == 0) ? asleep : (which == 1) ? core_ctl.vector_req : core_op.sleep_instr;
    end while (s !== lvl && n < bound);
    if (s !== lvl) begin
      $display("Error wait_%0d expected %b seen %b", which, lvl, s);
      num_errors++;
      final_report();
    end
  endtask

  // Enables exactly one source: 0-7 peripheral 1, 8 peripheral 2, 9-11 core, 12 port change
  task automatic setup_src(input logic global_irq_enable);
    logic [2:0] en;
    en = (src == 12) ? 3'h1 : (src >= 9) ? 3'(1 << (src - 9)) : 3'h0;
    reg_write(ADDR_PORTB_IOC, 8'hFF);
    reg_write(ADDR_PERIPHERAL_INTERRUPT_ENABLE_1, (src < 8) ? 8'(1 << src) : 8'h00);
    reg_write(ADDR_PERIPHERAL_INTERRUPT_ENABLE_2, {7'h00, src == 8});
    reg_write(ADDR_INTCTL, {global_irq_enable, 1'b1, en, 3'h0});
  endtask

  task automatic pulse_src;
    @(posedge sys_clk);
    if (src < 8) peripheral_interrupt_flags_1_set <= 8'(1 << src);
    else if (src == 8) peripheral_interrupt_flags_2_set <= 1'b1;
    else if (src == 12) portb_change <= 1'b1;
    else core_flag_set <= 3'(1 << (src - 9));
    @(posedge sys_clk);
    peripheral_interrupt_flags_1_set      <= 8'h00;
    peripheral_interrupt_flags_2_set      <= 1'b0;
    portb_change  <= 1'b0;
    core_flag_set <= 3'h0;
  endtask

  task automatic clear_flags;
    reg_write(ADDR_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    reg_write(ADDR_PERIPHERAL_INTERRUPT_FLAGS_2, 8'h00);
    reg_write(ADDR_INTCTL, 8'h00);
    reg_write(ADDR_EVT_STATUS, 8'h07);
  endtask

  task automatic go_sleep;
    @(posedge sys_clk);
    sleep_req <= 1'b1;
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    wait_cond(2, 1'b1, 40);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, reg_wr, reg_rd, peripheral_interrupt_flags_2_set, portb_change, sleep_req, slow} = 7'b1000000;
    {reg_addr, reg_wdata, peripheral_interrupt_flags_1_set, core_flag_set, dhist} = '0;
    void'($urandom(64));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, the narrow register and an unmapped place
    for (int a = 0; a < 16; a++) begin
      check_reg("reset_value", 4'(a), (a == 6) ? STATUS_RESET : (a == 7) ? 8'h01 : 8'h00);
    end
    reg_write(ADDR_PERIPHERAL_INTERRUPT_ENABLE_2, 8'hFF);
    check_reg("peripheral_interrupt_enable_2_bits", ADDR_PERIPHERAL_INTERRUPT_ENABLE_2, PERIPHERAL_INTERRUPT_ENABLE_2_MASK);
    reg_write(4'hF, 8'hFF);
    check_reg("unmapped", 4'hF, 8'h00);
    // Wake already pending with global enable clear: sleep is a no-op
    reg_write(ADDR_EVT_MASK, 8'h01);
    src = $urandom_range(12, 0);
    setup_src(1'b0);
    pulse_src();
    w0 = wdt_cnt;
    s0 = slp_cnt;
    go_sleep();
    repeat (12) @(negedge sys_clk);
    check("nop_no_sleep", 16'(slp_cnt - s0), 16'h0);
    check("wdt_nop", 16'(wdt_cnt - w0), 16'h0);
    check_reg("status_nop", ADDR_STATUS, STATUS_RESET);
    check("irq_on", irq, 1'b1);
    reg_write(ADDR_EVT_MASK, 8'h00);
    @(negedge sys_clk);
    check("irq_masked", irq, 1'b0);
    clear_flags();
    check_reg("evt_cleared", ADDR_EVT_STATUS, 8'h00);
    // Real sleeps: every oscillator mode vectors, then one in-line wake
    for (int i = 0; i < 6; i++) begin
      src = $urandom_range(12, 0);
      reg_write(ADDR_OSC_MODE, (i == 5) ? 8'h03 : 8'(i));
      setup_src(i != 5);
      w0 = wdt_cnt;
      v0 = vec_cnt;
      go_sleep();
      wait_cond(0, 1'b1, 40);
      check("stall_osc", {core_ctl.stall, core_ctl.osc_enable}, 2'b10);
      check_reg("status_sleep", ADDR_STATUS, 8'h02);
      check("wdt_sleep", 16'(wdt_cnt - w0), 16'h1);
      pulse_src();
      wait_cond((i == 5) ? 0 : 1, i != 5, 1200);
      if (i < 5) begin
        check("wake_delay", (i < 3) ? (n >= 1024 && n <= 1064) : (n <= 40), 1'b1);
        check("dummy_cycles", dhist, 3'b110);
        check("vector_addr", core_ctl.vector_addr, IRQ_VECTOR);
      end else begin
        check("inline_wake", n <= 40, 1'b1);
        repeat (60) @(negedge sys_clk);
        check("no_vector", 16'(vec_cnt - v0), 16'h0);
      end
      check_reg("evt_sleep_wake", ADDR_EVT_STATUS, 8'h06);
      clear_flags();
    end
    // Wake arrives while a slow sleep opcode is still executing
    slow = 1'b1;
    src = $urandom_range(12, 0);
    reg_write(ADDR_OSC_MODE, 8'h02);
    setup_src(1'b0);
    w0 = wdt_cnt;
    go_sleep();
    pulse_src();
    repeat (1100) @(negedge sys_clk);
    check("wdt_late", 16'(wdt_cnt - w0), 16'h1);
    check("awake_late", asleep, 1'b0);
    check_reg("status_late", ADDR_STATUS, 8'h02);
    check_reg("evt_late", ADDR_EVT_STATUS, 8'h06);
    final_report();
  end
endmodule
`default_nettype wire
